// ==== logic/scope_trig_pkg.sv ====
// Shared types and constants of the trigger qualifier
package scope_trig_pkg;
  localparam int CW = 24;
  localparam int NCH = 4;
  localparam int EW = 6;
  localparam logic [3:0] EEPROM_CTRL = 4'hA;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [EW-1:0] EDGE_ADDR1 = 6'h08;
  localparam logic [EW-1:0] EDGE_ADDR2 = 6'h11;
  localparam logic [EW-1:0] EDGE_ONE7 = 6'h11;
  localparam logic [EW-1:0] EDGE_TWO7 = 6'h1A;
  localparam logic [EW-1:0] EDGE_ONE10 = 6'h1A;
  localparam logic [EW-1:0] EDGE_TWO10 = 6'h22;
  localparam logic [3:0] ADDR_BYTES7 = 4'h1;
  localparam logic [3:0] ADDR_BYTES10 = 4'h2;
  localparam logic [3:0] LEN_MIN = 4'h1;
  localparam logic [3:0] LEN_MAX = 4'hC;

  typedef enum logic [1:0] {
    MODE_DROP = 2'h0, MODE_RUNT = 2'h1, MODE_PAT = 2'h3, MODE_I2C = 2'h2
  } mode_t;
  typedef enum logic [1:0] {LIM_LT, LIM_GT, LIM_IN, LIM_OUT} limit_t;
  typedef enum logic [1:0] {
    LOGIC_AND, LOGIC_OR, LOGIC_NAND, LOGIC_NOR
  } combine_t;
  typedef enum logic [1:0] {CH_DC, CH_LOW, CH_HIGH} chsel_t;
  typedef enum logic [2:0] {
    I2C_START, I2C_STOP, I2C_RESTART, I2C_NOACK,
    I2C_EEPROM, I2C_ADDR7, I2C_ADDR10, I2C_LENGTH
  } i2ccond_t;
  typedef enum logic [1:0] {CMP_EQ, CMP_LT, CMP_GT} cmp_t;
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_FRAME = 2'b01} phase_t;

  typedef struct packed {
    mode_t mode;
    logic dropoutVariant;
    logic slopeFall;
    logic [CW-1:0] timeout;
    logic runtNeg;
    limit_t limit;
    logic [CW-1:0] limLow;
    logic [CW-1:0] limHigh;
    chsel_t [NCH-1:0] chSel;
    combine_t patLogic;
    i2ccond_t i2cCond;
    logic addrTen;
    logic addrCare;
    logic [9:0] addrPattern;
    logic [7:0] firstDataPattern;
    logic firstCare;
    logic [7:0] secondDataPattern;
    logic secondCare;
    logic twoData;
    cmp_t eepromCmp;
    logic [3:0] byteLength;
  } cfg_t;

  typedef struct packed {
    logic level;
    logic runtLo;
    logic runtHi;
    logic [NCH-1:0] pat;
    logic scl;
    logic sda;
  } probe_t;
endpackage

// ==== logic/i2c_trigger_decoder.sv ====
// Serial bus frame decoder raising I2C trigger conditions
`timescale 1ns/1ps
`default_nettype none
module i2c_trigger_decoder
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic active,
  input wire logic scl,
  input wire logic sda,
  input wire scope_trig_pkg::cfg_t cfg,
  output logic hit
);
  typedef struct packed {
    logic scl;
    logic sda;
    scope_trig_pkg::phase_t ph;
    logic [scope_trig_pkg::EW-1:0] edgeCnt;
    logic [3:0] bitCnt;
    logic [3:0] byteCnt;
    logic [7:0] shift;
    logic addrOk;
    logic data1Ok;
    logic eepArm;
    logic hit;
  } ist_t;

  ist_t q;
  ist_t n;
  logic sclRise;
  logic startCond;
  logic stopCond;
  logic [7:0] nShift;
  logic [3:0] addrBytes;
  logic isCond;

  assign sclRise = scl & ~q.scl;
  assign startCond = scl & q.scl & ~sda & q.sda;
  assign stopCond = scl & q.scl & sda & ~q.sda;
  assign nShift = {q.shift[6:0], sda};
  assign addrBytes = cfg.addrTen ? scope_trig_pkg::ADDR_BYTES10
                                 : scope_trig_pkg::ADDR_BYTES7;
  assign hit = q.hit;

  always_comb
  begin
    n = q;
    n.scl = scl;
    n.sda = sda;
    n.hit = 1'b0;
    isCond = 1'b0;
    if (!active)
    begin
      n.ph = scope_trig_pkg::PH_IDLE;
      n.eepArm = 1'b0;
    end
    else if (startCond)
    begin
      // Repeated start also opens a fresh frame
      if (cfg.i2cCond == scope_trig_pkg::I2C_START)
        n.hit = 1'b1;
      if (cfg.i2cCond == scope_trig_pkg::I2C_RESTART
          && q.ph == scope_trig_pkg::PH_FRAME)
        n.hit = 1'b1;
      n.ph = scope_trig_pkg::PH_FRAME;
      n.edgeCnt = '0;
      n.bitCnt = '0;
      n.byteCnt = '0;
      n.eepArm = 1'b0;
      n.addrOk = 1'b1;
      n.data1Ok = 1'b1;
    end
    else if (stopCond)
    begin
      if (cfg.i2cCond == scope_trig_pkg::I2C_STOP)
        n.hit = 1'b1;
      if (cfg.i2cCond == scope_trig_pkg::I2C_LENGTH
          && q.ph == scope_trig_pkg::PH_FRAME
          && q.byteCnt == 4'(cfg.byteLength + addrBytes))
        n.hit = 1'b1;
      n.ph = scope_trig_pkg::PH_IDLE;
    end
    else if (q.ph == scope_trig_pkg::PH_FRAME && sclRise)
    begin
      n.shift = nShift;
      if (q.edgeCnt != '1)
        n.edgeCnt = q.edgeCnt + 1'b1;
      n.bitCnt = (q.bitCnt == scope_trig_pkg::BIT_ACK) ? '0
                                                       : q.bitCnt + 1'b1;
      if (q.bitCnt == scope_trig_pkg::BIT_ACK)
      begin
        if (q.byteCnt != '1)
          n.byteCnt = q.byteCnt + 1'b1;
        if (sda && cfg.i2cCond == scope_trig_pkg::I2C_NOACK)
          n.hit = 1'b1;
        if (q.eepArm && cfg.i2cCond == scope_trig_pkg::I2C_EEPROM)
        begin
          case (cfg.eepromCmp)
            scope_trig_pkg::CMP_LT: isCond = q.shift < cfg.firstDataPattern;
            scope_trig_pkg::CMP_GT: isCond = q.shift > cfg.firstDataPattern;
            default: isCond = q.shift == cfg.firstDataPattern;
          endcase
          n.hit = isCond;
        end
        if (q.byteCnt == '0 && q.shift[7:4] == scope_trig_pkg::EEPROM_CTRL
            && q.shift[0] && !sda)
          n.eepArm = 1'b1;
      end
      if (cfg.addrCare && n.edgeCnt == scope_trig_pkg::EDGE_ADDR1)
        n.addrOk = cfg.addrTen ? nShift[2:1] == cfg.addrPattern[9:8]
                               : nShift[7:1] == cfg.addrPattern[6:0];
      if (cfg.addrCare && cfg.addrTen
          && n.edgeCnt == scope_trig_pkg::EDGE_ADDR2)
        n.addrOk = q.addrOk && nShift == cfg.addrPattern[7:0];
      if (cfg.i2cCond == scope_trig_pkg::I2C_ADDR7
          || cfg.i2cCond == scope_trig_pkg::I2C_ADDR10)
      begin
        if (n.edgeCnt == (cfg.addrTen ? scope_trig_pkg::EDGE_ONE10
                                      : scope_trig_pkg::EDGE_ONE7))
        begin
          n.data1Ok = !cfg.firstCare || nShift == cfg.firstDataPattern;
          n.hit = q.addrOk && n.data1Ok && !cfg.twoData;
        end
        if (cfg.twoData
            && n.edgeCnt == (cfg.addrTen ? scope_trig_pkg::EDGE_TWO10
                                         : scope_trig_pkg::EDGE_TWO7))
          n.hit = q.addrOk && q.data1Ok && (!cfg.secondCare
                  || nShift == cfg.secondDataPattern);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= n;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence startSeq;
    active && scl && $past(scl) && !sda && $past(sda);
  endsequence
  sequence stopSeq;
    active && scl && $past(scl) && sda && !$past(sda);
  endsequence

  start_fire_a: assert property (
    startSeq and cfg.i2cCond == scope_trig_pkg::I2C_START |=> hit)
    else $error("start condition missed");
  stop_fire_a: assert property (
    stopSeq and cfg.i2cCond == scope_trig_pkg::I2C_STOP |=> hit)
    else $error("stop condition missed");
  ack_bit_a: assert property (
    cfg.i2cCond == scope_trig_pkg::I2C_NOACK && hit
    |-> $past(q.bitCnt) == scope_trig_pkg::BIT_ACK && $past(sda))
    else $error("no-ack trigger outside a high ack bit");
  frame_edge_a: assert property (
    cfg.i2cCond == scope_trig_pkg::I2C_ADDR10 && !cfg.twoData && hit
    |-> q.edgeCnt == scope_trig_pkg::EDGE_ONE10)
    else $error("ten-bit frame trigger on wrong edge");
endmodule
`default_nettype wire

// ==== logic/scope_trigger_qualifier.sv ====
// Trigger qualifier: dropout, runt, pattern and serial bus triggers
`timescale 1ns/1ps
`default_nettype none
module scope_trigger_qualifier
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic armed,
  input wire scope_trig_pkg::cfg_t cfg,
  input wire scope_trig_pkg::probe_t probes,
  output logic trigger
);
  typedef struct packed {
    scope_trig_pkg::probe_t s1;
    scope_trig_pkg::probe_t s2;
    scope_trig_pkg::probe_t pv;
    scope_trig_pkg::cfg_t cfg;
    logic dropRun;
    logic dropDone;
    logic [scope_trig_pkg::CW-1:0] dropCnt;
    logic runtOn;
    logic runtReach;
    logic [scope_trig_pkg::CW-1:0] runtCnt;
    logic patTrue;
    logic [scope_trig_pkg::CW-1:0] patCnt;
    logic trig;
  } st_t;

  st_t q;
  st_t n;
  logic rise;
  logic fall;
  logic startEdge;
  logic stopEdge;
  logic runtA;
  logic runtAPrev;
  logic runtB;
  logic [scope_trig_pkg::NCH-1:0] chCare;
  logic [scope_trig_pkg::NCH-1:0] chMatch;
  logic allMatch;
  logic anyMatch;
  logic patNow;
  logic i2cActive;
  logic i2cHit;
  logic dropFire;
  logic runtFire;
  logic patFire;

  function automatic logic limitOk
  (
    input logic [scope_trig_pkg::CW-1:0] w,
    input scope_trig_pkg::cfg_t c
  );
    case (c.limit)
      scope_trig_pkg::LIM_LT: limitOk = w < c.limLow;
      scope_trig_pkg::LIM_GT: limitOk = w > c.limLow;
      scope_trig_pkg::LIM_IN: limitOk = w > c.limLow && w < c.limHigh;
      default: limitOk = w < c.limLow || w > c.limHigh;
    endcase
  endfunction

  // Slope detection on the synchronised trigger-level comparator
  assign rise = q.s2.level & ~q.pv.level;
  assign fall = ~q.s2.level & q.pv.level;
  assign startEdge = q.cfg.slopeFall ? fall : rise;
  assign stopEdge = q.cfg.slopeFall ? rise : fall;

  // Negative polarity swaps and inverts the two thresholds
  assign runtA = q.cfg.runtNeg ? ~q.s2.runtHi : q.s2.runtLo;
  assign runtAPrev = q.cfg.runtNeg ? ~q.pv.runtHi : q.pv.runtLo;
  assign runtB = q.cfg.runtNeg ? ~q.s2.runtLo : q.s2.runtHi;

  // Per-channel pattern terms
  for (genvar i = 0; i < scope_trig_pkg::NCH; i++)
  begin : g_ch
    assign chCare[i] = q.cfg.chSel[i] != scope_trig_pkg::CH_DC;
    assign chMatch[i] = (q.cfg.chSel[i] == scope_trig_pkg::CH_HIGH)
                        ? q.s2.pat[i] : ~q.s2.pat[i];
  end

  assign allMatch = &(chMatch | ~chCare);
  assign anyMatch = |(chMatch & chCare);

  always_comb
  begin
    case (q.cfg.patLogic)
      scope_trig_pkg::LOGIC_AND: patNow = allMatch;
      scope_trig_pkg::LOGIC_OR: patNow = anyMatch;
      scope_trig_pkg::LOGIC_NAND: patNow = ~allMatch;
      scope_trig_pkg::LOGIC_NOR: patNow = ~anyMatch;
      default: patNow = 1'b0;
    endcase
    patNow = patNow & (|chCare);
  end

  assign i2cActive = armed && q.cfg.mode == scope_trig_pkg::MODE_I2C;
  assign trigger = q.trig;

  i2c_trigger_decoder u_i2c
  (
    .clock(clock),
    .resetn(resetn),
    .active(i2cActive),
    .scl(q.s2.scl),
    .sda(q.s2.sda),
    .cfg(q.cfg),
    .hit(i2cHit)
  );

  always_comb
  begin
    n = q;
    dropFire = 1'b0;
    runtFire = 1'b0;
    patFire = 1'b0;
    n.s1 = probes;
    n.s2 = q.s1;
    n.pv = q.s2;
    n.trig = 1'b0;
    if (!armed)
    begin
      n.cfg = cfg;
      n.dropRun = 1'b0;
      n.dropDone = 1'b0;
      n.runtOn = 1'b0;
      n.patTrue = 1'b0;
    end
    else
    begin
      // Dropout: timing runs in sample-clock cycles
      if (q.cfg.dropoutVariant && stopEdge)
        n.dropRun = 1'b0;
      else if (startEdge)
      begin
        n.dropRun = 1'b1;
        n.dropDone = 1'b0;
        n.dropCnt = '0;
      end
      else if (q.dropRun && !q.dropDone)
      begin
        if (q.dropCnt > q.cfg.timeout)
        begin
          dropFire = 1'b1;
          n.dropDone = 1'b1;
        end
        else
          n.dropCnt = q.dropCnt + 1'b1;
      end

      // Runt: start on first threshold, watch the second
      if (runtA && !runtAPrev)
      begin
        n.runtOn = 1'b1;
        n.runtReach = runtB;
        n.runtCnt = '0;
      end
      else if (q.runtOn && !runtA)
      begin
        n.runtOn = 1'b0;
        runtFire = !q.runtReach && limitOk(q.runtCnt, q.cfg);
      end
      else if (q.runtOn)
      begin
        if (runtB)
          n.runtReach = 1'b1;
        if (q.runtCnt != '1)
          n.runtCnt = q.runtCnt + 1'b1;
      end

      // Pattern duration timer
      n.patTrue = patNow;
      if (patNow && !q.patTrue)
        n.patCnt = '0;
      else if (patNow && q.patCnt != '1)
        n.patCnt = q.patCnt + 1'b1;
      if (!patNow && q.patTrue)
        patFire = limitOk(q.patCnt, q.cfg);

      case (q.cfg.mode)
        scope_trig_pkg::MODE_DROP: n.trig = dropFire;
        scope_trig_pkg::MODE_RUNT: n.trig = runtFire;
        scope_trig_pkg::MODE_PAT: n.trig = patFire;
        scope_trig_pkg::MODE_I2C: n.trig = i2cHit;
        default: n.trig = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= n;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence dropStartSeq;
    armed && startEdge && !(q.cfg.dropoutVariant && stopEdge);
  endsequence
  sequence patEndSeq;
    armed && q.patTrue && !patNow;
  endsequence

  drop_start_a: assert property (
    dropStartSeq |=> q.dropRun && q.dropCnt == '0 && !q.dropDone)
    else $error("dropout timer not restarted on start slope");
  drop_fire_a: assert property (
    armed && q.cfg.mode == scope_trig_pkg::MODE_DROP && trigger
    |-> $past(q.dropCnt) > q.cfg.timeout && $past(q.dropRun))
    else $error("dropout fired before timeout");
  drop_stop_a: assert property (
    armed && q.cfg.dropoutVariant && stopEdge |=> !q.dropRun)
    else $error("state dropout not cleared by opposite slope");
  runt_miss_a: assert property (
    armed && q.cfg.mode == scope_trig_pkg::MODE_RUNT && trigger
    |-> !$past(q.runtReach) && $past(q.runtOn))
    else $error("runt fired on a full pulse");
  runt_width_a: assert property (
    armed && q.cfg.mode == scope_trig_pkg::MODE_RUNT && trigger
    |-> limitOk($past(q.runtCnt), q.cfg))
    else $error("runt width outside qualifier");
  pat_timer_a: assert property (
    armed && patNow && !q.patTrue |=> q.patCnt == '0 ##1 q.patCnt <= 1)
    else $error("pattern timer not started on true edge");
  pat_end_a: assert property (
    patEndSeq and q.cfg.mode == scope_trig_pkg::MODE_PAT
    and limitOk(q.patCnt, q.cfg) |=> trigger)
    else $error("pattern end did not trigger");
  pat_none_a: assert property (
    armed && q.cfg.mode == scope_trig_pkg::MODE_PAT && !(|chCare)
    && $past(armed) && $past(armed, 2) |-> !trigger)
    else $error("pattern of all don't care triggered");
  cfg_hold_a: assert property (
    armed && $past(armed) |-> $stable(q.cfg))
    else $error("configuration changed while armed");
endmodule
`default_nettype wire

// ==== tb/probe_source.sv ====
// Stand-in for the circuit under test: comparator outputs and an I2C bus
`timescale 1ns/1ps
`default_nettype none
module probe_source
(
  input wire logic clock,
  output var scope_trig_pkg::probe_t probes
);
  // Bus lines rest high as if pulled up
  initial probes = 9'h003;

  task automatic drive(input int kind, input logic [3:0] v);
    @(posedge clock);
    case (kind)
      0: probes.level <= v[0];
      1: {probes.runtHi, probes.runtLo} <= v[1:0];
      default: probes.pat <= v;
    endcase
  endtask

  task automatic bus_step(input logic c, input logic d);
    @(posedge clock);
    probes.scl <= c;
    probes.sda <= d;
    @(posedge clock);
  endtask

  task automatic start_cond();
    bus_step(1'b0, 1'b1);
    bus_step(1'b1, 1'b1);
    bus_step(1'b1, 1'b0);
    bus_step(1'b0, 1'b0);
  endtask

  task automatic stop_cond();
    bus_step(1'b0, 1'b0);
    bus_step(1'b1, 1'b0);
    bus_step(1'b1, 1'b1);
  endtask

  task automatic clock_bit(input logic d);
    bus_step(1'b0, d);
    bus_step(1'b1, d);
    bus_step(1'b0, d);
  endtask

  // Byte MSB first, then the ninth bit: high means no acknowledge
  task automatic send_byte(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--)
      clock_bit(b[i]);
    clock_bit(ack);
  endtask
endmodule
`default_nettype wire

// ==== tb/scope_trigger_qualifier_test.sv ====
// Self-checking bench for the trigger qualifier
`timescale 1ns/1ps
`default_nettype none
module scope_trigger_qualifier_test;
  logic clock;
  logic resetn;
  logic armed;
  scope_trig_pkg::cfg_t cfg;
  scope_trig_pkg::probe_t probes;
  logic trigger;
  logic counting;
  logic lvl;
  int errors;
  int checked;
  int fired;
  // mode, select, channels, limit, idle, active, cycles, triggers expected
  int rows [0:36][0:7] = '{
    '{3, 0, 6, 1, 0, 1, 8, 1}, '{3, 0, 6, 1, 0, 1, 1, 0},
    '{3, 1, 10, 1, 0, 1, 8, 1}, '{3, 2, 6, 1, 1, 0, 8, 1},
    '{3, 3, 10, 1, 1, 0, 8, 1}, '{3, 0, 0, 1, 0, 15, 8, 0},
    '{3, 0, 6, 0, 0, 1, 8, 0},
    '{1, 0, 0, 1, 0, 1, 6, 1}, '{1, 0, 0, 1, 0, 3, 6, 0},
    '{1, 1, 0, 1, 3, 1, 6, 1}, '{1, 1, 0, 1, 3, 0, 6, 0},
    '{1, 0, 0, 2, 0, 1, 6, 1}, '{1, 0, 0, 3, 0, 1, 6, 0},
    '{1, 0, 0, 0, 0, 1, 6, 0},
    '{0, 0, 0, 0, 1, 0, 30, 1}, '{0, 0, 0, 0, 1, 0, 12, 0},
    '{0, 1, 0, 0, 1, 0, 30, 1}, '{0, 1, 0, 0, 0, 0, 30, 0},
    '{0, 3, 0, 0, 0, 0, 30, 1}, '{0, 2, 0, 0, 0, 0, 30, 1},
    '{2, 0, 0, 0, 0, 165, 0, 1}, '{2, 1, 0, 0, 0, 165, 0, 1},
    '{2, 2, 0, 0, 0, 165, 0, 0}, '{2, 3, 0, 0, 0, 165, 0, 0},
    '{2, 4, 0, 0, 0, 165, 0, 0}, '{2, 5, 0, 0, 0, 165, 0, 1},
    '{2, 7, 0, 0, 0, 165, 0, 1}, '{2, 5, 0, 0, 0, 65, 0, 0},
    '{2, 5, 0, 0, 1, 64, 0, 1}, '{2, 3, 0, 0, 1, 64, 0, 1},
    '{2, 4, 0, 0, 1, 80, 2, 1}, '{2, 4, 0, 0, 1, 65, 0, 0},
    '{2, 2, 0, 0, 2, 64, 0, 1}, '{2, 0, 0, 0, 2, 64, 0, 2},
    '{2, 6, 0, 0, 3, 165, 4, 1}, '{2, 5, 0, 0, 1, 64, 8, 1},
    '{2, 4, 0, 0, 1, 80, 1, 1}};

  scope_trigger_qualifier i_dut
  (
    .clock(clock),
    .resetn(resetn),
    .armed(armed),
    .cfg(cfg),
    .probes(probes),
    .trigger(trigger)
  );

  probe_source i_src
  (
    .clock(clock),
    .probes(probes)
  );

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock)
    if (counting && trigger === 1'b1)
      fired <= fired + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic scope_trig_pkg::cfg_t setup(input int r [0:7]);
    scope_trig_pkg::cfg_t c;
    c = '0;
    c.mode = scope_trig_pkg::mode_t'(2'(r[0]));
    c.dropoutVariant = r[1][0];
    c.slopeFall = r[1][1];
    c.timeout = 24'h00_0014;
    c.runtNeg = r[1][0];
    c.limit = scope_trig_pkg::limit_t'(2'(r[3]));
    c.limLow = 24'h00_0002;
    c.limHigh = 24'h00_000A;
    for (int i = 0; i < scope_trig_pkg::NCH; i++)
      c.chSel[i] = scope_trig_pkg::chsel_t'(2'(r[2] >> (2 * i)));
    c.patLogic = scope_trig_pkg::combine_t'(2'(r[1]));
    c.i2cCond = scope_trig_pkg::i2ccond_t'(3'(r[1]));
    c.addrCare = 1'b1;
    c.addrTen = r[6][2];
    c.twoData = r[6][3];
    c.secondDataPattern = 8'h60;
    c.secondCare = 1'b1;
    c.addrPattern = 10'h050;
    c.firstDataPattern = 8'(r[5]);
    c.firstCare = 1'b1;
    c.eepromCmp = scope_trig_pkg::cmp_t'(2'(r[6]));
    c.byteLength = 4'h1;
    return c;
  endfunction

  task automatic toggles(input int n);
    repeat (n)
    begin
      lvl = ~lvl;
      i_src.drive(0, {3'b000, lvl});
      repeat (3) @(posedge clock);
    end
  endtask

  // Frame 0 write and data, 1 read with a refused byte, 2 repeated start,
  // 3 ten-bit address and data
  task automatic frame(input int f);
    i_src.start_cond();
    if (f == 3)
      i_src.send_byte(8'hF0, 1'b0);
    i_src.send_byte((f == 1) ? 8'hA1 : (f == 3) ? 8'h50 : 8'hA0, 1'b0);
    if (f == 2)
      i_src.start_cond();
    i_src.send_byte((f == 0 || f == 3) ? 8'hA5 : 8'h40, 1'b0);
    if (f == 1)
      i_src.send_byte(8'h60, 1'b1);
    i_src.stop_cond();
  endtask

  // how: 0 plain, 1 config changed while armed, 2 never armed
  task automatic run_row(input int r [0:7], input int how, output int seen);
    @(posedge clock);
    armed <= 1'b0;
    counting <= 1'b0;
    cfg <= setup(r);
    lvl = 1'b0;
    if (r[0] != 2)
      i_src.drive(r[0], (r[0] == 0) ? 4'h0 : 4'(r[4]));
    repeat (6) @(posedge clock);
    fired <= 0;
    armed <= (how != 2);
    counting <= 1'b1;
    @(posedge clock);
    if (how == 1)
      cfg <= '0;
    case (r[0])
      0:
      begin
        toggles(9 + r[4]);
        lvl = r[4][0];
        i_src.drive(0, {3'b000, lvl});
        repeat (r[6] - 1) @(posedge clock);
        toggles(10);
      end
      2: frame(r[4]);
      default:
      begin
        i_src.drive(r[0], 4'(r[5]));
        repeat (r[6] - 1) @(posedge clock);
        i_src.drive(r[0], 4'(r[4]));
      end
    endcase
    repeat (8) @(posedge clock);
    counting <= 1'b0;
    @(posedge clock);
    seen = fired;
  endtask

  initial
  begin
    repeat (60000) @(posedge clock);
    errors++;
    wrap_up();
  end

  initial
  begin
    int seen;
    resetn = 1'b0;
    armed = 1'b0;
    cfg = '0;
    counting = 1'b0;
    lvl = 1'b0;
    fired = 0;
    errors = 0;
    checked = 0;
    repeat (8) @(posedge clock);
    check(32'(trigger), 32'h0000_0000);
    resetn <= 1'b1;
    for (int n = 0; n < 37; n++)
    begin
      run_row(rows[n], 0, seen);
      case (rows[n][0])
        0: check(seen, rows[n][7]);
        1: check(seen, rows[n][7]);
        3: check(seen, rows[n][7]);
        default: check(seen, rows[n][7]);
      endcase
    end
    run_row(rows[5], 0, seen);
    check(seen, 0);
    run_row(rows[0], 1, seen);
    check(seen, 1);
    run_row(rows[14], 1, seen);
    check(seen, 1);
    run_row(rows[0], 2, seen);
    check(seen, 0);
    run_row(rows[20], 2, seen);
    check(seen, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
